// ===== xcvr_reset_cdr_lock_control.sv
// Transceiver block reset, power-down and CDR lock-mode controller.
// Assumes fabric reset pins are asynchronous levels and a classic Wishbone master.
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module xcvr_reset_cdr_lock_control #(
	parameter int NCH = 4
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Fabric reset and lock controls.
	input wire logic [NCH-1:0] chan_rst_i,
	input wire logic powerdown_i,
	input wire logic [NCH-1:0] ref_lock_i,
	input wire logic [NCH-1:0] data_lock_i,
	// CDR frequency detector.
	input wire logic [NCH-1:0] ppm_ok_i,
	// Channel controls and status.
	output logic [NCH-1:0] rx_rst_o,
	output logic [NCH-1:0] tx_rst_o,
	output logic powerdown_o,
	output logic [NCH-1:0] ref_lock_state_o,
	output logic [NCH-1:0] freq_locked_o
);

	localparam int SW = 4 * NCH + 1;

	xcvr_rst_pkg::ctrl_t ctrl_reg;
	logic [NCH-1:0] bonded_reg;
	logic [NCH-1:0] manual;
	logic [NCH-1:0] req_sync;
	logic [NCH-1:0] ref_sync;
	logic [NCH-1:0] data_sync;
	logic [NCH-1:0] ppm_sync;
	logic pd_sync;
	logic [NCH-1:0] bond_next;
	logic group_req;
	logic [NCH-1:0] rx_rst_next;
	logic [NCH-1:0] tx_rst_next;
	logic tx_only_ok;
	logic pcie;
	logic access;
	logic [31:0] rd_data;
	logic [xcvr_rst_pkg::MAX_CH-1:0] mask_full;
	logic ctrl_wr;
	logic [xcvr_rst_pkg::CTRL_W-1:0] wr_field;

	// All fabric-side levels cross into the clock domain together.
	xcvr_sync2 #(
		.W(SW)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({powerdown_i, ppm_ok_i, data_lock_i, ref_lock_i, chan_rst_i}),
		.q_o({pd_sync, ppm_sync, data_sync, ref_sync, req_sync})
	);

	assign pcie = (ctrl_reg.mode == xcvr_rst_pkg::MODE_PCIE);
	// Transmit-only is refused where the receivers must stay bonded.
	assign tx_only_ok = ctrl_reg.tx_only && !pcie && (ctrl_reg.mode != xcvr_rst_pkg::MODE_XAUI);

	always_comb begin
		mask_full = xcvr_rst_pkg::bond_mask(ctrl_reg.mode);
		bond_next = mask_full[NCH-1:0];
		group_req = ctrl_reg.group_rst || (|(req_sync & bonded_reg));
		tx_rst_next = req_sync | (bonded_reg & {NCH{group_req}}) | {NCH{pd_sync}};
		rx_rst_next = tx_rst_next | {NCH{tx_only_ok}};
	end

	// The bonded mask follows the mode one edge after a control write.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bonded_reg <= '0;
		end else begin
			bonded_reg <= bond_next;
		end
	end

	// Channel resets stay high through reset so no lane starts before software is ready.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_rst_o <= '1;
		end else begin
			rx_rst_o <= rx_rst_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_rst_o <= '1;
		end else begin
			tx_rst_o <= tx_rst_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			powerdown_o <= 1'b1;
		end else begin
			powerdown_o <= pd_sync;
		end
	end

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch
			xcvr_lock_ctrl u_lock (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.rx_rst_i(rx_rst_o[c]),
				.auto_only_i(pcie),
				.ref_lock_i(ref_sync[c]),
				.data_lock_i(data_sync[c]),
				.ppm_ok_i(ppm_sync[c]),
				.ref_lock_state_o(ref_lock_state_o[c]),
				.freq_locked_o(freq_locked_o[c]),
				.manual_o(manual[c])
			);
		end
	endgenerate

	// Bus slave answers one cycle after each request and drops ack the next cycle.
	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Only byte lane 0 carries the control fields.
	assign ctrl_wr = access && wb_we_i && wb_sel_i[0] && (wb_adr_i == xcvr_rst_pkg::ADDR_CTRL);
	assign wr_field = wb_dat_i[xcvr_rst_pkg::CTRL_W-1:0];

	always_comb begin
		rd_data = '0;
		unique case (wb_adr_i)
			xcvr_rst_pkg::ADDR_CTRL: rd_data[xcvr_rst_pkg::CTRL_W-1:0] = ctrl_reg;
			xcvr_rst_pkg::ADDR_STATUS: begin
				rd_data[xcvr_rst_pkg::STAT_FREQ_LSB +: NCH] = freq_locked_o;
				rd_data[xcvr_rst_pkg::STAT_MANUAL_LSB +: NCH] = manual;
				rd_data[xcvr_rst_pkg::STAT_RXRST_LSB +: NCH] = rx_rst_o;
				rd_data[xcvr_rst_pkg::STAT_TXRST_LSB +: NCH] = tx_rst_o;
			end
			xcvr_rst_pkg::ADDR_BOND: begin
				rd_data[NCH-1:0] = bonded_reg;
				rd_data[xcvr_rst_pkg::BOND_PD_BIT] = powerdown_o;
			end
			default: rd_data = '0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= access;
		end
	end

	// Read data holds between reads so a slow master can still pick it up.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (access && !wb_we_i) begin
			wb_dat_o <= rd_data;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= xcvr_rst_pkg::CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg <= xcvr_rst_pkg::ctrl_t'(wr_field);
		end
	end

	// Assertions.
	property p_chan_reset;
		@(posedge clk_i) disable iff (rst_i)
		(|req_sync) |=> ((($past(req_sync)) & ~(tx_rst_o & rx_rst_o)) == '0);
	endproperty
	a_chan_reset: assert property (p_chan_reset) else $error("channel reset not applied");

	property p_powerdown;
		@(posedge clk_i) disable iff (rst_i)
		pd_sync |=> (powerdown_o && (&tx_rst_o) && (&rx_rst_o));
	endproperty
	a_powerdown: assert property (p_powerdown) else $error("power-down not applied");

	property p_group_reset;
		@(posedge clk_i) disable iff (rst_i)
		(|(req_sync & bonded_reg)) |=> (($past(bonded_reg) & ~tx_rst_o) == '0);
	endproperty
	a_group_reset: assert property (p_group_reset) else $error("bonded group not reset");

	sequence s_xaui_held;
		(ctrl_reg.mode == xcvr_rst_pkg::MODE_XAUI) [*2];
	endsequence

	property p_xaui_bond;
		@(posedge clk_i) disable iff (rst_i)
		s_xaui_held |-> (bonded_reg[3:0] == 4'hf && rx_rst_o == tx_rst_o);
	endproperty
	a_xaui_bond: assert property (p_xaui_bond) else $error("XAUI lanes not bonded");

	sequence s_txonly_x4;
		(ctrl_reg.tx_only && ctrl_reg.mode == xcvr_rst_pkg::MODE_BASIC_X4) [*2];
	endsequence

	property p_txonly_bond;
		@(posedge clk_i) disable iff (rst_i)
		s_txonly_x4 |-> (bonded_reg[3:0] == 4'hf && (&rx_rst_o));
	endproperty
	a_txonly_bond: assert property (p_txonly_bond) else $error("tx-only group not bonded");

	property p_bus_ack;
		@(posedge clk_i) disable iff (rst_i)
		access |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_bus_ack: assert property (p_bus_ack) else $error("bus ack not a single cycle");

	property p_pcie_auto;
		@(posedge clk_i) disable iff (rst_i)
		pcie |=> (manual == '0);
	endproperty
	a_pcie_auto: assert property (p_pcie_auto) else $error("PCIe mode left manual lock");

	property p_rst_ref;
		@(posedge clk_i) disable iff (rst_i)
		(|rx_rst_o) |=> (($past(rx_rst_o) & freq_locked_o) == '0);
	endproperty
	a_rst_ref: assert property (p_rst_ref) else $error("reset receiver kept data lock");

	property p_group_ctrl;
		@(posedge clk_i) disable iff (rst_i)
		ctrl_reg.group_rst |=> (($past(bonded_reg) & ~tx_rst_o) == '0);
	endproperty
	a_group_ctrl: assert property (p_group_ctrl) else $error("group reset bit ignored");

	property p_bond_x2;
		@(posedge clk_i) disable iff (rst_i)
		(ctrl_reg.mode == xcvr_rst_pkg::MODE_BASIC_X2) |=> (bonded_reg[1:0] == 2'b11);
	endproperty
	a_bond_x2: assert property (p_bond_x2) else $error("two-lane group not bonded");

	property p_ctrl_write;
		@(posedge clk_i) disable iff (rst_i)
		ctrl_wr |=> (ctrl_reg == xcvr_rst_pkg::ctrl_t'($past(wr_field)));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_ack_req;
		@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> $past(access);
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");

	property p_read_status;
		@(posedge clk_i) disable iff (rst_i)
		(access && !wb_we_i && wb_adr_i == xcvr_rst_pkg::ADDR_STATUS)
			|=> (wb_dat_o[xcvr_rst_pkg::STAT_FREQ_LSB +: NCH] == $past(freq_locked_o));
	endproperty
	a_read_status: assert property (p_read_status) else $error("status read stale");

	property p_unmapped_read;
		@(posedge clk_i) disable iff (rst_i)
		(access && !wb_we_i && wb_adr_i != xcvr_rst_pkg::ADDR_CTRL
			&& wb_adr_i != xcvr_rst_pkg::ADDR_STATUS && wb_adr_i != xcvr_rst_pkg::ADDR_BOND)
			|=> (wb_dat_o == '0);
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_powerup;
		@(posedge clk_i) disable iff (rst_i)
		(!rst_i && !pd_sync) |=> !powerdown_o;
	endproperty
	a_powerup: assert property (p_powerup) else $error("power-down stuck");

	property p_tx_release;
		@(posedge clk_i) disable iff (rst_i)
		(!rst_i && !pd_sync && !group_req && req_sync == '0) |=> (tx_rst_o == '0);
	endproperty
	a_tx_release: assert property (p_tx_release) else $error("transmit reset without cause");

endmodule // xcvr_reset_cdr_lock_control

`default_nettype wire

// ===== xcvr_rst_pkg.sv
// Shared constants and types for the transceiver reset and lock-mode controller.
// Assumes a single 25 MHz system clock and a classic Wishbone register bus.
`default_nettype none

package xcvr_rst_pkg;

	localparam int MAX_CH = 8;
	localparam int BUS_W = 32;

	// Register byte addresses.
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_BOND = 4'h8;

	// Status and bond register field positions.
	localparam int STAT_FREQ_LSB = 0;
	localparam int STAT_MANUAL_LSB = 8;
	localparam int STAT_RXRST_LSB = 16;
	localparam int STAT_TXRST_LSB = 24;
	localparam int BOND_PD_BIT = 8;

	// Functional mode field, software visible.
	typedef enum logic [2:0] {
		MODE_BASIC = 3'h0,
		MODE_BASIC_X2 = 3'h1,
		MODE_BASIC_X4 = 3'h2,
		MODE_XAUI = 3'h3,
		MODE_PCIE = 3'h4
	} func_mode_t;

	// Control register layout: bits 2:0 mode, bit 3 tx_only, bit 4 group reset.
	typedef struct packed {
		logic group_rst;
		logic tx_only;
		func_mode_t mode;
	} ctrl_t;

	localparam int CTRL_W = $bits(ctrl_t);
	localparam ctrl_t CTRL_RESET = '{group_rst: 1'b0, tx_only: 1'b0, mode: MODE_BASIC};

	typedef enum logic [1:0] {
		LM_AUTO = 2'h0,
		LM_MANUAL_REF = 2'h1,
		LM_MANUAL_DATA = 2'h2
	} lock_mode_t;

	typedef enum logic {
		CDR_LOCK_REF,
		CDR_LOCK_DATA
	} cdr_state_t;

	// Data-lock wins over reference-lock; both low leave the CDR automatic.
	function automatic lock_mode_t lock_decode(input logic ref_lock, input logic data_lock);
		if (data_lock) begin
			return LM_MANUAL_DATA;
		end else if (ref_lock) begin
			return LM_MANUAL_REF;
		end
		return LM_AUTO;
	endfunction

	// Channels that form the bonded group in each mode.
	function automatic logic [MAX_CH-1:0] bond_mask(input func_mode_t mode);
		unique case (mode)
			MODE_BASIC_X2: return 8'h03;
			MODE_BASIC_X4, MODE_XAUI, MODE_PCIE: return 8'h0f;
			default: return 8'h00;
		endcase
	endfunction

endpackage

`default_nettype wire

// ===== xcvr_sync2.sv
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module xcvr_sync2 #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Levels.
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			q_o <= '0;
		end else begin
			meta_reg <= d_i;
			q_o <= meta_reg;
		end
	end

endmodule // xcvr_sync2

`default_nettype wire

// ===== xcvr_lock_ctrl.sv
// Per-channel CDR lock controller and frequency-lock status.
// Assumes synchronised inputs on the system clock.
`timescale 1ns/1ps
`default_nettype none

module xcvr_lock_ctrl (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Controls.
	input wire logic rx_rst_i,
	input wire logic auto_only_i,
	input wire logic ref_lock_i,
	input wire logic data_lock_i,
	input wire logic ppm_ok_i,
	// Status.
	output logic ref_lock_state_o,
	output logic freq_locked_o,
	output logic manual_o
);

	xcvr_rst_pkg::lock_mode_t mode;
	xcvr_rst_pkg::cdr_state_t state_reg;
	xcvr_rst_pkg::cdr_state_t state_next;

	always_comb begin
		mode = xcvr_rst_pkg::lock_decode(ref_lock_i, data_lock_i);
		if (auto_only_i) begin
			mode = xcvr_rst_pkg::LM_AUTO;
		end
		state_next = state_reg;
		if (rx_rst_i) begin
			state_next = xcvr_rst_pkg::CDR_LOCK_REF;
		end else begin
			unique case (mode)
				xcvr_rst_pkg::LM_MANUAL_REF: state_next = xcvr_rst_pkg::CDR_LOCK_REF;
				xcvr_rst_pkg::LM_MANUAL_DATA: state_next = xcvr_rst_pkg::CDR_LOCK_DATA;
				default: state_next = ppm_ok_i ? xcvr_rst_pkg::CDR_LOCK_DATA
					: xcvr_rst_pkg::CDR_LOCK_REF;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= xcvr_rst_pkg::CDR_LOCK_REF;
			ref_lock_state_o <= 1'b1;
			freq_locked_o <= 1'b0;
			manual_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			ref_lock_state_o <= (state_next == xcvr_rst_pkg::CDR_LOCK_REF);
			freq_locked_o <= (state_next == xcvr_rst_pkg::CDR_LOCK_DATA);
			manual_o <= (mode != xcvr_rst_pkg::LM_AUTO);
		end
	end

	property p_manual_data;
		@(posedge clk_i) disable iff (rst_i)
		(!rx_rst_i && !auto_only_i && data_lock_i) |=> (freq_locked_o && manual_o);
	endproperty
	a_manual_data: assert property (p_manual_data) else $error("data-lock did not give lock");

	property p_manual_ref;
		@(posedge clk_i) disable iff (rst_i)
		(!rx_rst_i && !auto_only_i && ref_lock_i && !data_lock_i)
			|=> (!freq_locked_o && ref_lock_state_o && manual_o);
	endproperty
	a_manual_ref: assert property (p_manual_ref) else $error("ref-lock did not lower lock");

	property p_auto;
		@(posedge clk_i) disable iff (rst_i)
		(!rx_rst_i && (auto_only_i || (!ref_lock_i && !data_lock_i)))
			|=> (!manual_o && freq_locked_o == $past(ppm_ok_i));
	endproperty
	a_auto: assert property (p_auto) else $error("automatic lock not followed");

	property p_state_pair;
		@(posedge clk_i) disable iff (rst_i)
		(freq_locked_o != ref_lock_state_o);
	endproperty
	a_state_pair: assert property (p_state_pair) else $error("lock status and state disagree");

endmodule // xcvr_lock_ctrl

`default_nettype wire

// ===== xcvr_fabric_seq.sv
// Fabric-side reset sequencer model that drives the controller's reset and lock pins.
// Assumes the bench changes its request levels just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module xcvr_fabric_seq #(
	parameter int NCH = 4
) (
	// Clock.
	input wire logic clk_i,
	// Requests from the bench.
	input wire logic [NCH-1:0] rst_req_i,
	input wire logic [NCH-1:0] ref_req_i,
	input wire logic [NCH-1:0] data_req_i,
	input wire logic [NCH-1:0] wait_mask_i,
	// Controller pins.
	input wire logic [NCH-1:0] freq_locked_i,
	output logic [NCH-1:0] chan_rst_o,
	output logic [NCH-1:0] ref_lock_o,
	output logic [NCH-1:0] data_lock_o,
	output logic all_locked_o
);
	always_ff @(posedge clk_i) begin
		chan_rst_o <= rst_req_i;
		ref_lock_o <= ref_req_i;
		data_lock_o <= data_req_i;
	end

	assign all_locked_o = &(freq_locked_i | ~wait_mask_i);
endmodule // xcvr_fabric_seq

`default_nettype wire

// ===== tb_xcvr_reset_cdr_lock_control.sv
// Self-checking bench for the transceiver reset and lock-mode controller.
// Assumes the fabric model xcvr_fabric_seq and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module tb_xcvr_reset_cdr_lock_control;
	typedef struct packed {
		logic [3:0] r;
		logic [3:0] d;
		logic [3:0] p;
		logic [3:0] f;
	} row_t;
	localparam row_t ROWS [4] = '{'{4'h0, 4'h0, 4'hf, 4'hf}, '{4'hf, 4'h0, 4'hf, 4'h0},
		'{4'hf, 4'hf, 4'h0, 4'hf}, '{4'h5, 4'ha, 4'h3, 4'ha}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic [31:0] rd;
	logic wb_ack_o, powerdown_o, all_locked;
	logic powerdown_i = 1'b0;
	logic [3:0] chan_rst, ref_lock, data_lock, rx_rst_o, tx_rst_o, ref_lock_state_o, freq_locked_o;
	logic [3:0] rst_req = 4'h0, ref_req = 4'h0, data_req = 4'h0, wait_mask = 4'h0;
	logic [3:0] ppm_ok_i = 4'h0;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;

	xcvr_reset_cdr_lock_control #(.NCH(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.chan_rst_i(chan_rst), .powerdown_i(powerdown_i), .ref_lock_i(ref_lock),
		.data_lock_i(data_lock), .ppm_ok_i(ppm_ok_i), .rx_rst_o(rx_rst_o), .tx_rst_o(tx_rst_o),
		.powerdown_o(powerdown_o), .ref_lock_state_o(ref_lock_state_o),
		.freq_locked_o(freq_locked_o));

	xcvr_fabric_seq #(.NCH(4)) u_seq (.clk_i(clk_i), .rst_req_i(rst_req), .ref_req_i(ref_req),
		.data_req_i(data_req), .wait_mask_i(wait_mask), .freq_locked_i(freq_locked_o),
		.chan_rst_o(chan_rst), .ref_lock_o(ref_lock), .data_lock_o(data_lock),
		.all_locked_o(all_locked));

	always #20 clk_i = ~clk_i;

	task automatic test_done();
		if (fail_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Entered just after a rising edge; returns just after the edge that follows the release.
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic settle();
		repeat (8) @(posedge clk_i);
	endtask

	initial begin
		repeat (16) @(posedge clk_i);
		chk({powerdown_o, ref_lock_state_o, freq_locked_o, rx_rst_o, tx_rst_o}, 17'h1f0ff);
		rst_i <= 1'b0;
		settle();
		foreach (ROWS[i]) begin
			ref_req <= ROWS[i].r;
			data_req <= ROWS[i].d;
			ppm_ok_i <= ROWS[i].p;
			settle();
			chk({ref_lock_state_o, freq_locked_o}, {~ROWS[i].f, ROWS[i].f});
			wb(1'b0, xcvr_rst_pkg::ADDR_STATUS, 32'h0);
			chk(rd, {16'h0, 4'h0, ROWS[i].r | ROWS[i].d, 4'h0, ROWS[i].f});
		end
		ref_req <= 4'hf;
		data_req <= 4'h0;
		ppm_ok_i <= 4'hf;
		wb(1'b1, xcvr_rst_pkg::ADDR_CTRL, 32'h4);
		settle();
		chk(freq_locked_o, 4'hf);
		ref_req <= 4'h0;
		rst_req <= 4'h4;
		wb(1'b1, xcvr_rst_pkg::ADDR_CTRL, 32'h0);
		settle();
		chk({rx_rst_o, tx_rst_o, freq_locked_o}, 12'h44b);
		rst_req <= 4'h2;
		wb(1'b1, xcvr_rst_pkg::ADDR_CTRL, 32'h3);
		settle();
		chk({rx_rst_o, tx_rst_o}, 8'hff);
		wb(1'b0, xcvr_rst_pkg::ADDR_BOND, 32'h0);
		chk(rd, 32'h0f);
		rst_req <= 4'h0;
		data_req <= 4'hf;
		wait_mask <= 4'hf;
		settle();
		chk({all_locked, freq_locked_o}, 5'h1f);
		wb(1'b1, xcvr_rst_pkg::ADDR_CTRL, 32'h13);
		settle();
		chk({rx_rst_o, tx_rst_o}, 8'hff);
		rst_req <= 4'h1;
		wb(1'b1, xcvr_rst_pkg::ADDR_CTRL, 32'h9);
		settle();
		chk({rx_rst_o, tx_rst_o}, 8'hf3);
		wb(1'b0, xcvr_rst_pkg::ADDR_BOND, 32'h0);
		chk(rd, 32'h03);
		rst_req <= 4'h0;
		wb(1'b1, xcvr_rst_pkg::ADDR_CTRL, 32'ha);
		settle();
		chk({rx_rst_o, tx_rst_o}, 8'hf0);
		wb(1'b1, xcvr_rst_pkg::ADDR_CTRL, 32'hb);
		settle();
		chk({rx_rst_o, tx_rst_o}, 8'h00);
		rst_req <= 4'h0;
		powerdown_i <= 1'b1;
		wb(1'b1, xcvr_rst_pkg::ADDR_CTRL, 32'h0);
		settle();
		chk({powerdown_o, rx_rst_o, tx_rst_o}, 9'h1ff);
		wb(1'b0, xcvr_rst_pkg::ADDR_BOND, 32'h0);
		chk(rd[8], 1'b1);
		powerdown_i <= 1'b0;
		wb(1'b1, 4'hc, 32'h1f);
		wb(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, xcvr_rst_pkg::ADDR_CTRL, 32'h3);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({powerdown_o, ref_lock_state_o, freq_locked_o, rx_rst_o, tx_rst_o}, 17'h1f0ff);
		rst_i <= 1'b0;
		wb(1'b0, xcvr_rst_pkg::ADDR_CTRL, 32'h0);
		chk(rd, 32'h0);
		test_done();
	end
endmodule // tb_xcvr_reset_cdr_lock_control

`default_nettype wire
